// [rtl/tcw_pkg.sv]
package tcw_pkg;

  localparam int TCW_AW = 8;

  // Register byte offsets
  localparam logic [7:0] TCW_OFS_CMP1_HI = 8'h00;
  localparam logic [7:0] TCW_OFS_CMP1_LO = 8'h04;
  localparam logic [7:0] TCW_OFS_CMP2_HI = 8'h08;
  localparam logic [7:0] TCW_OFS_CMP2_LO = 8'h0c;
  localparam logic [7:0] TCW_OFS_CTRL1 = 8'h10;
  localparam logic [7:0] TCW_OFS_CTRL2 = 8'h14;
  localparam logic [7:0] TCW_OFS_CTRL3 = 8'h18;
  localparam logic [7:0] TCW_OFS_STATUS = 8'h1c;
  localparam logic [7:0] TCW_OFS_CNT_HI = 8'h20;
  localparam logic [7:0] TCW_OFS_CNT_LO = 8'h24;
  localparam logic [7:0] TCW_OFS_CAP1_HI = 8'h28;
  localparam logic [7:0] TCW_OFS_CAP1_LO = 8'h2c;

  // Reset and reload values
  localparam logic [15:0] TCW_CMP_RESET = 16'h8000;
  localparam logic [15:0] TCW_CNT_RELOAD = 16'hfffc;
  localparam logic [15:0] TCW_CAP_RESET = 16'h0000;
  localparam logic [7:0] TCW_CTRL_RESET = 8'h00;

  // Status bit positions
  localparam int TCW_SR_CAP1 = 7;
  localparam int TCW_SR_CMP1 = 6;
  localparam int TCW_SR_OVF = 5;
  localparam int TCW_SR_CMP2 = 3;

  // Prescaler: last divider state for each factor
  localparam logic [1:0] TCW_PSC_DIV2 = 2'h0;
  localparam logic [1:0] TCW_PSC_DIV4 = 2'h1;
  localparam logic [2:0] TCW_DIV2_LAST = 3'h1;
  localparam logic [2:0] TCW_DIV4_LAST = 3'h3;
  localparam logic [2:0] TCW_DIV8_LAST = 3'h7;

  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic [1:0] force_level_bit;
    logic compare_output_level2;
    logic capture_one_edge_select;
    logic compare_output_level1;
  } tcw_ctrl_one_t;

  typedef struct packed {
    logic [1:0] spare;
    logic [1:0] prescale_select;
    logic pwm_select;
    logic single_pulse_select;
    logic [1:0] compare_pin_dedicate;
  } tcw_ctrl_two_t;

  typedef struct packed {
    logic [3:0] spare;
    logic global_irq_select;
    logic overflow_irq_source_select;
    logic capture_irq_source_select;
    logic compare_irq_source_select;
  } tcw_ctrl_three_t;

  typedef struct packed {
    logic compare;
    logic capture;
    logic overflow;
    logic global;
  } tcw_irq_t;

endpackage

// [rtl/tcw_edge_sync.sv]
`timescale 1ns/1ps
module tcw_edge_sync
  import tcw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic pin,
  input wire logic edge_select,
  output logic edge_seen
);

  logic sync_a;
  logic sync_b;
  logic sync_c;
  wire rise = sync_b & ~sync_c;
  wire fall = ~sync_b & sync_c;

  // Two-stage synchroniser, then edge detection
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign edge_seen = edge_select ? rise : fall;

endmodule // tcw_edge_sync

// [rtl/tcw_timebase.sv]
`timescale 1ns/1ps
module tcw_timebase
  import tcw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [1:0] prescale_select,
  input wire logic reload,
  output logic tick,
  output logic overflow,
  output logic [15:0] count
);

  logic [2:0] div;
  wire [2:0] div_last = (prescale_select == TCW_PSC_DIV2) ? TCW_DIV2_LAST :
                        (prescale_select == TCW_PSC_DIV4) ? TCW_DIV4_LAST :
                        TCW_DIV8_LAST;

  assign tick = (div >= div_last);
  assign overflow = tick & ~reload & (count == 16'hffff);

  // Free-running up counter advanced once per prescaled tick
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div <= 3'h0;
      count <= TCW_CNT_RELOAD;
    end else begin
      div <= tick ? 3'h0 : div + 3'h1;
      if (reload) begin
        count <= TCW_CNT_RELOAD;
      end else if (tick) begin
        count <= count + 16'h0001;
      end
    end
  end

endmodule // tcw_timebase

// [rtl/tcw_top.sv]
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module tcw_top
  import tcw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [TCW_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_one_pin,
  output logic [1:0] compare_output_pin,
  output logic [1:0] compare_pin_enable,
  output tcw_irq_t irq
);

  function automatic logic [7:0] ofs_hi(input int ch);
    ofs_hi = (ch == 0) ? TCW_OFS_CMP1_HI : TCW_OFS_CMP2_HI;
  endfunction

  function automatic logic [7:0] ofs_lo(input int ch);
    ofs_lo = (ch == 0) ? TCW_OFS_CMP1_LO : TCW_OFS_CMP2_LO;
  endfunction

  tcw_ctrl_one_t control_one;
  tcw_ctrl_two_t control_two;
  tcw_ctrl_three_t control_three;
  logic [1:0][15:0] cmp_value;
  logic [1:0] cmp_inhibit;
  logic [15:0] cap_value;
  logic [3:0] flag;
  logic [3:0] flag_armed;
  logic [1:0] pin_latch;

  logic tick;
  logic overflow;
  logic [15:0] count;
  logic cap_edge;

  // Bus phase decode
  wire acc = psel & penable & pready;
  wire wr_en = acc & pwrite;
  wire rd_en = acc & ~pwrite;
  wire [7:0] wbyte = pwdata[7:0];
  wire sr_rd = rd_en & (paddr == TCW_OFS_STATUS);
  wire cnt_lo_acc = acc & (paddr == TCW_OFS_CNT_LO);
  wire cnt_lo_wr = cnt_lo_acc & pwrite;
  wire cap_lo_acc = acc & (paddr == TCW_OFS_CAP1_LO);

  wire mapped = (paddr == TCW_OFS_CMP1_HI) | (paddr == TCW_OFS_CMP1_LO) |
                (paddr == TCW_OFS_CMP2_HI) | (paddr == TCW_OFS_CMP2_LO) |
                (paddr == TCW_OFS_CTRL1) | (paddr == TCW_OFS_CTRL2) |
                (paddr == TCW_OFS_CTRL3) | (paddr == TCW_OFS_STATUS) |
                (paddr == TCW_OFS_CNT_HI) | (paddr == TCW_OFS_CNT_LO) |
                (paddr == TCW_OFS_CAP1_HI) | (paddr == TCW_OFS_CAP1_LO);

  // Mode selection; PWM wins over single pulse
  wire pwm_mode = control_two.pwm_select;
  wire opm_mode = control_two.single_pulse_select & ~pwm_mode;
  wire [1:0] dedicate = control_two.compare_pin_dedicate;
  wire [1:0] force_on = control_one.force_level_bit;
  wire level1 = control_one.compare_output_level1;
  wire level2 = control_one.compare_output_level2;

  // Counter reload sources
  wire [1:0] match;
  wire pwm_reload = pwm_mode & match[1];
  wire opm_reload = opm_mode & cap_edge;
  wire cnt_reload = cnt_lo_wr | pwm_reload | opm_reload;

  tcw_timebase u_timebase (
    .sys_clk(sys_clk),
    .srst(srst),
    .prescale_select(control_two.prescale_select),
    .reload(cnt_reload),
    .tick(tick),
    .overflow(overflow),
    .count(count)
  );

  tcw_edge_sync u_cap_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .pin(capture_one_pin),
    .edge_select(control_one.capture_one_edge_select),
    .edge_seen(cap_edge)
  );

  // Compare value registers and match detection
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_cmp
      wire hi_wr = wr_en & (paddr == ofs_hi(ch));
      wire lo_wr = wr_en & (paddr == ofs_lo(ch));

      always_ff @(posedge sys_clk) begin
        if (srst) begin
          cmp_value[ch] <= TCW_CMP_RESET;
          cmp_inhibit[ch] <= 1'b0;
        end else begin
          if (hi_wr) begin
            cmp_value[ch][15:8] <= wbyte;
          end
          if (lo_wr) begin
            cmp_value[ch][7:0] <= wbyte;
          end
          if (hi_wr) begin
            cmp_inhibit[ch] <= 1'b1;
          end else if (lo_wr) begin
            cmp_inhibit[ch] <= 1'b0;
          end
        end
      end

      // Evaluated once per counter tick
      assign match[ch] = tick & ~cmp_inhibit[ch] &
                         (count == cmp_value[ch]);
    end
  endgenerate

  // Capture one value latched on each active edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cap_value <= TCW_CAP_RESET;
    end else if (cap_edge) begin
      cap_value <= count;
    end
  end

  // Flag set conditions, indexed 0 cmp1, 1 cmp2, 2 overflow, 3 capture
  wire set_cmp1 = match[0] & ~pwm_mode & ~opm_mode;
  wire set_cmp2 = match[1] & ~pwm_mode;
  wire [3:0] flag_set = {cap_edge, overflow, set_cmp2, set_cmp1};
  wire [3:0] flag_lo_acc = {cap_lo_acc, cnt_lo_acc,
                            acc & (paddr == TCW_OFS_CMP2_LO),
                            acc & (paddr == TCW_OFS_CMP1_LO)};

  // Two-step clear: status read arms, low-byte access clears; set wins
  genvar f;
  generate
    for (f = 0; f < 4; f++) begin : g_flag
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          flag[f] <= 1'b0;
          flag_armed[f] <= 1'b0;
        end else begin
          if (flag_set[f]) begin
            flag[f] <= 1'b1;
          end else if (flag_lo_acc[f] & flag_armed[f]) begin
            flag[f] <= 1'b0;
          end
          if (sr_rd & flag[f]) begin
            flag_armed[f] <= 1'b1;
          end else if (flag_lo_acc[f] | ~flag[f]) begin
            flag_armed[f] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Pin one next level by mode
  wire pin1_normal = (match[0] & dedicate[0]) ? level1 : pin_latch[0];
  wire pin1_pwm = match[0] ? level1 :
                  match[1] ? level2 : pin_latch[0];
  wire pin1_opm = cap_edge ? level2 :
                  match[0] ? level1 : pin_latch[0];
  wire pin1_mode = pwm_mode ? pin1_pwm :
                   opm_mode ? pin1_opm : pin1_normal;
  wire next_pin1 = force_on[0] ? level1 : pin1_mode;

  // Pin two; in PWM mode compare two only steers pin one
  wire pin2_hit = match[1] & dedicate[1] & ~pwm_mode;
  wire pin2_mode = pin2_hit ? level2 : pin_latch[1];
  wire next_pin2 = force_on[1] ? level2 : pin2_mode;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_latch <= 2'h0;
      compare_output_pin <= 2'h0;
      compare_pin_enable <= 2'h0;
    end else begin
      pin_latch <= {next_pin2, next_pin1};
      compare_output_pin <= {next_pin2, next_pin1};
      compare_pin_enable <= dedicate;
    end
  end

  // Interrupt requests
  wire global_sel = control_three.global_irq_select;
  wire cmp_req = (flag[0] | flag[1]) &
                 control_one.compare_irq_enable &
                 (control_three.compare_irq_source_select | global_sel);
  wire cap_req = flag[3] & control_one.capture_irq_enable &
                 (control_three.capture_irq_source_select | global_sel);
  wire ovf_req = flag[2] & control_one.overflow_irq_enable &
                 (control_three.overflow_irq_source_select | global_sel);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq <= '0;
    end else begin
      irq.compare <= cmp_req & ~global_sel;
      irq.capture <= cap_req & ~global_sel;
      irq.overflow <= ovf_req & ~global_sel;
      irq.global <= global_sel &
                    (cmp_req | cap_req | ovf_req);
    end
  end

  // Control register writes; spare bits stay zero
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      control_one <= TCW_CTRL_RESET;
      control_two <= TCW_CTRL_RESET;
      control_three <= TCW_CTRL_RESET;
    end else if (wr_en) begin
      if (paddr == TCW_OFS_CTRL1) begin
        control_one <= wbyte;
      end
      if (paddr == TCW_OFS_CTRL2) begin
        control_two <= {2'h0, wbyte[5:0]};
      end
      if (paddr == TCW_OFS_CTRL3) begin
        control_three <= {4'h0, wbyte[3:0]};
      end
    end
  end

  // Status byte view
  logic [7:0] status_byte;
  always_comb begin
    status_byte = 8'h00;
    status_byte[TCW_SR_CMP1] = flag[0];
    status_byte[TCW_SR_CMP2] = flag[1];
    status_byte[TCW_SR_OVF] = flag[2];
    status_byte[TCW_SR_CAP1] = flag[3];
  end

  // Read data selection
  wire [7:0] rd_byte =
    (paddr == TCW_OFS_CMP1_HI) ? cmp_value[0][15:8] :
    (paddr == TCW_OFS_CMP1_LO) ? cmp_value[0][7:0] :
    (paddr == TCW_OFS_CMP2_HI) ? cmp_value[1][15:8] :
    (paddr == TCW_OFS_CMP2_LO) ? cmp_value[1][7:0] :
    (paddr == TCW_OFS_CTRL1) ? control_one :
    (paddr == TCW_OFS_CTRL2) ? control_two :
    (paddr == TCW_OFS_CTRL3) ? control_three :
    (paddr == TCW_OFS_STATUS) ? status_byte :
    (paddr == TCW_OFS_CNT_HI) ? count[15:8] :
    (paddr == TCW_OFS_CNT_LO) ? count[7:0] :
    (paddr == TCW_OFS_CAP1_HI) ? cap_value[15:8] :
    (paddr == TCW_OFS_CAP1_LO) ? cap_value[7:0] : 8'h00;

  // APB slave: one wait state, answer registered
  wire access_start = psel & penable & ~pready;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access_start;
      pslverr <= access_start & ~mapped;
      if (access_start & ~pwrite) begin
        prdata <= {24'h000000, rd_byte};
      end
    end
  end

endmodule // tcw_top

// [bench/tcw_chk_sva.sv]
`timescale 1ns/1ps
module tcw_chk
  import tcw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [TCW_AW-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] compare_output_pin,
  input wire logic [1:0] compare_pin_enable,
  input wire tcw_irq_t irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  reset_pins_a: assert property ($fell(srst) |->
    compare_output_pin == 2'h0 && compare_pin_enable == 2'h0 && irq == 4'h0)
    else $error("Outputs not low after reset");
  ready_wait_a: assert property (psel && penable && !$past(penable) |->
    !pready ##1 pready) else $error("Access not one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("Ready longer than one cycle");
  err_map_a: assert property (pready && paddr > 8'h2c |-> pslverr)
    else $error("Unmapped access without error");
  err_ok_a: assert property (pready && paddr <= 8'h2c && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("Mapped access flagged error");
  rdata_top_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("Read data upper bits set");
  irq_split_a: assert property (irq.global |->
    !irq.compare && !irq.capture && !irq.overflow)
    else $error("Separate request beside shared one");
  pin_own_a: assert property ($changed(compare_pin_enable) |->
    $past(pready && pwrite && paddr == 8'h14, 2))
    else $error("Pin dedication changed without write");
  c_wr: cover property (pready && pwrite);
  c_glob: cover property (irq.global);
  c_pin: cover property ($rose(compare_output_pin[0]));
endmodule // tcw_chk
bind tcw_top tcw_chk tcw_chk_i (.sys_clk(sys_clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .compare_output_pin(compare_output_pin),
  .compare_pin_enable(compare_pin_enable), .irq(irq));

// [bench/tcw_pin_model.sv]
`timescale 1ns/1ps
module tcw_pin_model (
  input wire logic sys_clk,
  input wire logic fire,
  output logic capture_one_pin
);
  // Trigger source: one high pulse on the capture pin per fire
  int hold = 0;
  initial capture_one_pin = 1'b0;
  always @(posedge sys_clk) begin
    if (fire) hold <= 8;
    else if (hold > 0) hold <= hold - 1;
    capture_one_pin <= fire || hold > 1;
  end
endmodule // tcw_pin_model

// [bench/test_timer_compare_waveform_unit.sv]
`timescale 1ns/1ps
module test_timer_compare_waveform_unit
  import tcw_pkg::*;
;
  logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [7:0] paddr = 8'h00, rdv;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, errv, capture_one_pin;
  logic [1:0] compare_output_pin, compare_pin_enable;
  tcw_irq_t irq;
  int error_cnt = 0, num_checks = 0, cnt;
  tcw_top tcw_top_i (.sys_clk(sys_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_one_pin(capture_one_pin), .compare_output_pin(compare_output_pin),
    .compare_pin_enable(compare_pin_enable), .irq(irq));
  tcw_pin_model tcw_pin_model_i (.sys_clk(sys_clk), .fire(fire),
    .capture_one_pin(capture_one_pin));
  initial forever #2 sys_clk = ~sys_clk;
  task report_and_stop();
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    rdv = prdata[7:0];
    errv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d); xfer(1, a, d); endtask
  task rd(input logic [7:0] a); xfer(0, a, 8'h00); endtask
  task wait_pin(input int i, input logic v, input int n);
    cnt = 0;
    while (compare_output_pin[i] !== v && cnt < n) begin
      @(posedge sys_clk);
      cnt++;
    end
  endtask
  task do_reset();
    srst <= 1;
    repeat (3) @(posedge sys_clk);
    srst <= 0;
  endtask
  task t_reset_vals();
    rd(TCW_OFS_CMP1_HI); chk(rdv, 8'h80);
    rd(TCW_OFS_CMP2_LO); chk(rdv, 8'h00);
    rd(8'h30); chk({errv, rdv}, 9'h100);
    chk(compare_output_pin, 2'h0);
  endtask
  task t_match_irq();
    wr(TCW_OFS_CMP1_HI, 8'h00); rd(TCW_OFS_STATUS);
    wr(TCW_OFS_CMP1_LO, 8'h05);
    wr(TCW_OFS_CTRL1, 8'h41); wr(TCW_OFS_CTRL2, 8'h01);
    wr(TCW_OFS_CNT_LO, 8'h00);
    wait_pin(0, 1, 100); chk(cnt < 100, 1);
    chk(irq, 4'h0);
    wr(TCW_OFS_CTRL3, 8'h01); repeat (2) @(posedge sys_clk);
    chk(irq, 4'h8);
    wr(TCW_OFS_CTRL3, 8'h08); repeat (2) @(posedge sys_clk);
    chk(irq, 4'h1);
    rd(TCW_OFS_STATUS); chk(rdv[6], 1);
    rd(TCW_OFS_CMP1_LO); rd(TCW_OFS_STATUS); chk(rdv[6], 0);
    chk(irq, 4'h0);
  endtask
  task t_inhibit();
    wr(TCW_OFS_CTRL1, 8'h04); wr(TCW_OFS_CNT_LO, 8'h00);
    wr(TCW_OFS_CMP2_HI, 8'h00); repeat (30) @(posedge sys_clk);
    rd(TCW_OFS_STATUS); chk(rdv[3], 0);
    wr(TCW_OFS_CMP2_LO, 8'h40); repeat (200) @(posedge sys_clk);
    rd(TCW_OFS_STATUS); chk(rdv[3], 1);
    chk(compare_output_pin[1], 0);
    wr(TCW_OFS_CTRL2, 8'h02); wr(TCW_OFS_CNT_LO, 8'h00);
    wait_pin(1, 1, 200); chk(cnt < 200, 1);
  endtask
  task t_force();
    wr(TCW_OFS_CTRL2, 8'h01); wr(TCW_OFS_CTRL1, 8'h09);
    repeat (2) @(posedge sys_clk); chk(compare_output_pin[0], 1);
    chk(compare_pin_enable, 2'h1);
    wr(TCW_OFS_CTRL1, 8'h08);
    repeat (2) @(posedge sys_clk); chk(compare_output_pin[0], 0);
    rd(TCW_OFS_STATUS); chk(rdv & 8'h48, 8'h00);
  endtask
  task t_pwm();
    wr(TCW_OFS_CTRL1, 8'h01); wr(TCW_OFS_CTRL2, 8'h0d);
    wr(TCW_OFS_CMP1_HI, 8'h00); wr(TCW_OFS_CMP1_LO, 8'h04);
    wr(TCW_OFS_CMP2_HI, 8'h00); wr(TCW_OFS_CMP2_LO, 8'h0a);
    wr(TCW_OFS_CNT_LO, 8'h00);
    for (int p = 0; p < 3; p++) begin
      wr(TCW_OFS_CTRL2, {2'h0, p[1:0], 4'hd});
      repeat (2) begin
        wait_pin(0, 1, 400); wait_pin(0, 0, 400);
      end
      chk(cnt, 12 << p);
    end
    rd(TCW_OFS_STATUS); chk(rdv & 8'h48, 8'h00);
  endtask
  task t_pulse();
    wr(TCW_OFS_CTRL1, 8'h06); wr(TCW_OFS_CTRL2, 8'h05);
    wr(TCW_OFS_CMP1_HI, 8'h00); wr(TCW_OFS_CMP1_LO, 8'h06);
    repeat (4) @(posedge sys_clk); chk(compare_output_pin[0], 0);
    fire <= 1; @(posedge sys_clk); fire <= 0;
    wait_pin(0, 1, 10); chk(cnt < 10, 1);
    wait_pin(0, 0, 60); chk(cnt >= 18 && cnt <= 22, 1);
    rd(TCW_OFS_STATUS); chk(rdv & 8'hc0, 8'h80);
  endtask
  initial begin
    do_reset(); t_reset_vals();
    t_match_irq();
    do_reset(); t_inhibit();
    do_reset(); t_force();
    do_reset(); t_pwm();
    do_reset(); t_pulse();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    report_and_stop();
  end
endmodule // test_timer_compare_waveform_unit
